//--- rtl/hpd_decode.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01: respond only while device select is low
// R02: board ties select low for twelve-bit decode
// R03: board ORs upper address onto select
// R04: unused disk2 pins carry upper address bits
// R05: registers eight bits, disk data sixteen
// R06: accept programmed and DMA transfers
// R07: default bases at reset, relocatable later
// R08: read and write reach separate registers
// R09: leading-n signals are active low
// R10: disk2 selects undriven until channel activated
// R11: per-block decode ranges as tabled
// R12: unmapped access never drives data bus

module hpd_decode (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  // host bus
  input  wire logic [11:0]          sa_i,
  input  wire logic                 device_select_low_i,
  input  wire logic                 ior_low_i,
  input  wire logic                 iow_low_i,
  input  wire logic                 dack_low_i,
  input  wire logic                 addr_mode16_i,
  // configuration writes
  input  wire hpd_pkg::hpd_cfg_wr_t cfg_i,
  // disk channel 1 selects
  output logic                      disk1_select_a_low_o,
  output logic                      disk1_select_b_low_o,
  // disk channel 2 select pins, shared with upper address
  input  wire logic                 disk2_select_a_low_i,
  output logic                      disk2_select_a_low_o,
  output logic                      disk2_select_a_oe_o,
  input  wire logic                 disk2_select_b_low_i,
  output logic                      disk2_select_b_low_o,
  output logic                      disk2_select_b_oe_o,
  input  wire logic                 disk2_irq_in_i,
  // block selection
  output hpd_pkg::hpd_sel_t         sel_o,
  output logic                      data_drive_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  hpd_pkg::hpd_state_t st_reg;
  hpd_pkg::hpd_state_t st_next;

  logic                d1_hit1;
  logic                d1_hit2;
  logic                d2_hit1;
  logic                d2_hit2;
  logic                d2_drive;

  function automatic logic in_win(input logic [11:0] addr, input logic [11:0] base,
                                  input logic [3:0] len);
    logic [11:0] diff;
    diff   = addr - base;
    in_win = (addr >= base) && (diff < {8'h00, len});
  endfunction

  function automatic logic [2:0] ofs_of(input logic [11:0] addr, input logic [11:0] base);
    logic [11:0] diff;
    diff   = addr - base;
    ofs_of = diff[2:0];
  endfunction

  // ****************************************************************
  // decode
  // ****************************************************************
  logic             rd;
  logic             wr;
  logic             acc;
  logic             upper_ok;
  logic             dma;
  logic [5:0]       hit;
  logic [5:0]       en;
  logic             par_ext;
  logic [3:0]       par_len;
  logic             disk_b2;
  hpd_pkg::hpd_sel_t sel;

  always_comb begin
    rd       = ~ior_low_i; // R09
    wr       = ~iow_low_i; // R09
    dma      = ~dack_low_i; // R06
    // in wide mode the select pin carries SA12, disk2 pins carry SA13..15
    upper_ok = ~addr_mode16_i
             | ~(disk2_select_a_low_i | disk2_select_b_low_i | disk2_irq_in_i); // R04
    acc      = ~device_select_low_i & (rd ^ wr) & upper_ok; // R01
    en       = st_reg.enable;
    en[hpd_pkg::HPD_BLK_DISK2] = st_reg.enable[hpd_pkg::HPD_BLK_DISK2] & ~addr_mode16_i; // R04
    par_len  = (st_reg.pmode == hpd_pkg::HPD_PM_EPP || st_reg.pmode == hpd_pkg::HPD_PM_ECP_EPP)
             ? hpd_pkg::PAR_WIDE_LEN : hpd_pkg::PAR_NARROW_LEN; // R11
    par_ext  = (st_reg.pmode == hpd_pkg::HPD_PM_ECP || st_reg.pmode == hpd_pkg::HPD_PM_ECP_EPP)
             && in_win(sa_i, st_reg.base[hpd_pkg::HPD_BLK_PAR] + hpd_pkg::PAR_EXT_OFS,
                       hpd_pkg::PAR_EXT_LEN); // R11
    hit[0]   = in_win(sa_i, st_reg.base[0], hpd_pkg::FLOPPY_LEN)
             && ofs_of(sa_i, st_reg.base[0]) != hpd_pkg::FLOPPY_HOLE; // R11
    hit[1]   = in_win(sa_i, st_reg.base[1], hpd_pkg::DISK_LEN)
             || in_win(sa_i, st_reg.disk1_base2, hpd_pkg::DISK_BASE2_LEN); // R11
    hit[2]   = in_win(sa_i, st_reg.base[2], hpd_pkg::DISK_LEN)
             || in_win(sa_i, st_reg.disk2_base2, hpd_pkg::DISK_BASE2_LEN); // R11
    hit[3]   = in_win(sa_i, st_reg.base[3], par_len) || par_ext; // R11
    hit[4]   = in_win(sa_i, st_reg.base[4], hpd_pkg::SERIAL_LEN); // R11
    hit[5]   = in_win(sa_i, st_reg.base[5], hpd_pkg::SERIAL_LEN); // R11
    // a DMA cycle goes to the floppy data port whatever the address
    if (dma) begin
      hit = 6'h01; // R06
    end
    hit      = hit & en & {6{acc}}; // R01
    disk_b2  = 1'b0;

    sel = '0;
    // lowest logical device wins an overlap
    for (int i = hpd_pkg::NUM_BLK - 1; i >= 0; i--) begin
      if (hit[i]) begin
        sel.onehot    = 6'h00;
        sel.onehot[i] = 1'b1;
        sel.offset    = ofs_of(sa_i, st_reg.base[i]);
      end
    end
    if (sel.onehot[1] || sel.onehot[2]) begin
      disk_b2 = sel.onehot[1] ? !in_win(sa_i, st_reg.base[1], hpd_pkg::DISK_LEN)
                              : !in_win(sa_i, st_reg.base[2], hpd_pkg::DISK_LEN);
      if (disk_b2) begin
        sel.offset = 3'h0;
      end
    end
    if (sel.onehot[3] && par_ext && !in_win(sa_i, st_reg.base[3], par_len)) begin
      sel.ext_win = 1'b1;
      sel.offset  = ofs_of(sa_i, st_reg.base[3] + hpd_pkg::PAR_EXT_OFS);
    end
    if (dma && sel.onehot[0]) begin
      sel.offset = hpd_pkg::FLOPPY_DATA_OFS; // R06
    end
    sel.second = disk_b2;
    sel.rd     = (|sel.onehot) & rd; // R08
    sel.wr     = (|sel.onehot) & wr; // R08
    sel.dma    = (|sel.onehot) & dma; // R06
    sel.wide16 = (sel.onehot[1] || sel.onehot[2]) && !disk_b2
               && sel.offset == hpd_pkg::DISK_DATA_OFS; // R05
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next       = st_reg;
    st_next.sel   = sel;
    st_next.drive = (|sel.onehot) & rd; // R12
    if (cfg_i.load) begin
      if (cfg_i.second && cfg_i.block == hpd_pkg::HPD_BLK_DISK1) begin
        st_next.disk1_base2 = cfg_i.base; // R07
      end else if (cfg_i.second && cfg_i.block == hpd_pkg::HPD_BLK_DISK2) begin
        st_next.disk2_base2 = cfg_i.base; // R07
      end else if (cfg_i.block <= hpd_pkg::HPD_BLK_COM2) begin
        st_next.base[cfg_i.block]   = cfg_i.base; // R07
        st_next.enable[cfg_i.block] = cfg_i.enable; // R10
      end
      if (cfg_i.block == hpd_pkg::HPD_BLK_PAR) begin
        st_next.pmode = cfg_i.pmode;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg.base        <= {hpd_pkg::COM2_BASE_RST, hpd_pkg::COM1_BASE_RST,
                             hpd_pkg::PAR_BASE_RST, hpd_pkg::DISK2_BASE_RST,
                             hpd_pkg::DISK1_BASE_RST, hpd_pkg::FLOPPY_BASE_RST}; // R07
      st_reg.disk1_base2 <= hpd_pkg::DISK1_BASE2_RST;
      st_reg.disk2_base2 <= hpd_pkg::DISK2_BASE2_RST;
      st_reg.enable      <= hpd_pkg::ENABLE_RST; // R10
      st_reg.pmode       <= hpd_pkg::HPD_PM_SPP;
      st_reg.sel         <= '0;
      st_reg.drive       <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // disk select pins
  // ****************************************************************
  always_comb begin
    d1_hit1  = sel.onehot[1] && !disk_b2;
    d1_hit2  = sel.onehot[1] && disk_b2;
    d2_hit1  = sel.onehot[2] && !disk_b2;
    d2_hit2  = sel.onehot[2] && disk_b2;
    d2_drive = st_next.enable[hpd_pkg::HPD_BLK_DISK2] & ~addr_mode16_i; // R10
  end

  hpd_disk_select u_disk1 (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .hit_base1_i (d1_hit1),
    .hit_base2_i (d1_hit2),
    .drive_en_i  (1'b1),
    .sel_a_low_o (disk1_select_a_low_o),
    .sel_b_low_o (disk1_select_b_low_o),
    .sel_oe_o    ()
  );

  logic d2_oe;

  hpd_disk_select u_disk2 (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .hit_base1_i (d2_hit1),
    .hit_base2_i (d2_hit2),
    .drive_en_i  (d2_drive),
    .sel_a_low_o (disk2_select_a_low_o),
    .sel_b_low_o (disk2_select_b_low_o),
    .sel_oe_o    (d2_oe)
  );

  assign disk2_select_a_oe_o = d2_oe;
  assign disk2_select_b_oe_o = d2_oe;
  assign sel_o               = st_reg.sel;
  assign data_drive_o        = st_reg.drive;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_idle_no_drive: assert property (@(posedge core_clk_i) disable iff (rst_i) // R01
    device_select_low_i |=> !data_drive_o && sel_o.onehot == 6'h00)
    else $error("response while device select high");

  a_unmapped_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i) // R12
    data_drive_o |-> (|sel_o.onehot) && sel_o.rd)
    else $error("data bus driven without a selected block");

  a_dir_exclusive: assert property (@(posedge core_clk_i) disable iff (rst_i) // R08
    !(sel_o.rd && sel_o.wr) && $onehot0(sel_o.onehot))
    else $error("read and write or two blocks at once");

  a_wide_disk_only: assert property (@(posedge core_clk_i) disable iff (rst_i) // R05
    sel_o.wide16 |-> (sel_o.onehot[1] || sel_o.onehot[2]) && sel_o.offset == 3'h0
                     && !sel_o.second)
    else $error("sixteen-bit transfer outside disk data port");

  a_floppy_hole: assert property (@(posedge core_clk_i) disable iff (rst_i) // R11
    sel_o.onehot[0] |-> sel_o.offset != 3'h6)
    else $error("floppy selected at unmapped offset");

  a_dma_floppy: assert property (@(posedge core_clk_i) disable iff (rst_i) // R06
    (!device_select_low_i && !dack_low_i && (ior_low_i ^ iow_low_i) && st_reg.enable[0]
     && !(addr_mode16_i && (disk2_select_a_low_i || disk2_select_b_low_i || disk2_irq_in_i)))
    |=> sel_o.dma && sel_o.onehot == 6'h01 && sel_o.offset == 3'h5)
    else $error("dma cycle not routed to floppy data port");

  a_upper_bits: assert property (@(posedge core_clk_i) disable iff (rst_i) // R04
    (addr_mode16_i && disk2_irq_in_i) |=> sel_o.onehot == 6'h00 && !disk2_select_a_oe_o)
    else $error("access taken with upper address bits set");

  a_disk2_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i) // R10
    (!st_reg.enable[2] ##1 !st_reg.enable[2]) |-> !disk2_select_a_oe_o && !disk2_select_b_oe_o)
    else $error("disk2 selects driven before activation");

  a_reset_bases: assert property (@(posedge core_clk_i) // R07
    (rst_i ##1 !rst_i) |-> st_reg.base[0] == 12'h3f0 && st_reg.base[4] == 12'h3f8)
    else $error("default bases missing after reset");

endmodule // hpd_decode

//--- rtl/hpd_pkg.sv
package hpd_pkg;

  // ****************************************************************
  // sizes and counts
  // ****************************************************************
  localparam int unsigned NUM_BLK = 6;
  localparam int unsigned ADDR_W  = 12;

  // ****************************************************************
  // default base addresses after reset
  // ****************************************************************
  localparam logic [11:0] FLOPPY_BASE_RST = 12'h3f0;
  localparam logic [11:0] DISK1_BASE_RST  = 12'h1f0;
  localparam logic [11:0] DISK1_BASE2_RST = 12'h3f6;
  localparam logic [11:0] DISK2_BASE_RST  = 12'h170;
  localparam logic [11:0] DISK2_BASE2_RST = 12'h376;
  localparam logic [11:0] PAR_BASE_RST    = 12'h378;
  localparam logic [11:0] COM1_BASE_RST   = 12'h3f8;
  localparam logic [11:0] COM2_BASE_RST   = 12'h2f8;
  // floppy, disk1, par, com1, com2 on; disk2 off until activated
  localparam logic [5:0]  ENABLE_RST      = 6'h3b;

  // ****************************************************************
  // decode windows
  // ****************************************************************
  localparam logic [3:0]  FLOPPY_LEN       = 4'h8;
  localparam logic [2:0]  FLOPPY_HOLE      = 3'h6;
  localparam logic [2:0]  FLOPPY_DATA_OFS  = 3'h5;
  localparam logic [3:0]  SERIAL_LEN       = 4'h8;
  localparam logic [3:0]  PAR_NARROW_LEN   = 4'h4;
  localparam logic [3:0]  PAR_WIDE_LEN     = 4'h8;
  localparam logic [11:0] PAR_EXT_OFS      = 12'h400;
  localparam logic [3:0]  PAR_EXT_LEN      = 4'h3;
  localparam logic [3:0]  DISK_LEN         = 4'h8;
  localparam logic [3:0]  DISK_BASE2_LEN   = 4'h1;
  localparam logic [2:0]  DISK_DATA_OFS    = 3'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  // order follows the logical device numbers 0..5
  typedef enum logic [2:0] {
    HPD_BLK_FLOPPY, HPD_BLK_DISK1, HPD_BLK_DISK2, HPD_BLK_PAR, HPD_BLK_COM1, HPD_BLK_COM2
  } hpd_blk_t;

  typedef enum logic [1:0] {
    HPD_PM_SPP, HPD_PM_EPP, HPD_PM_ECP, HPD_PM_ECP_EPP
  } hpd_pmode_t;

  typedef struct packed {
    logic       load;
    hpd_blk_t   block;
    logic       second;
    logic [11:0] base;
    logic       enable;
    hpd_pmode_t pmode;
  } hpd_cfg_wr_t;

  typedef struct packed {
    logic [5:0] onehot;
    logic [2:0] offset;
    logic       ext_win;
    logic       second;
    logic       rd;
    logic       wr;
    logic       dma;
    logic       wide16;
  } hpd_sel_t;

  typedef struct packed {
    logic [5:0][11:0] base;
    logic [11:0]      disk1_base2;
    logic [11:0]      disk2_base2;
    logic [5:0]       enable;
    hpd_pmode_t       pmode;
    hpd_sel_t         sel;
    logic             drive;
  } hpd_state_t;

  typedef struct packed {
    logic a_low;
    logic b_low;
    logic oe;
  } hpd_dsel_state_t;

endpackage

//--- rtl/hpd_disk_select.sv
`timescale 1ns/1ps

module hpd_disk_select (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // decode results
  input  wire logic hit_base1_i,
  input  wire logic hit_base2_i,
  input  wire logic drive_en_i,
  // select pins
  output logic      sel_a_low_o,
  output logic      sel_b_low_o,
  output logic      sel_oe_o
);

  hpd_pkg::hpd_dsel_state_t st_reg;
  hpd_pkg::hpd_dsel_state_t st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.a_low = ~hit_base1_i;
    st_next.b_low = ~hit_base2_i;
    // pull-ups hold the pins high while the driver is off
    st_next.oe    = drive_en_i; // R10
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_reg <= '{a_low: 1'b1, b_low: 1'b1, oe: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sel_a_low_o = st_reg.a_low;
  assign sel_b_low_o = st_reg.b_low;
  assign sel_oe_o    = st_reg.oe;

  a_sel_off_idle: assert property (@(posedge core_clk_i) disable iff (rst_i) // R10
    !drive_en_i |=> !sel_oe_o)
    else $error("select pins driven while channel inactive");

endmodule // hpd_disk_select

//--- verif/hpd_host_model.sv
`timescale 1ns/1ps

module hpd_host_model (
  // clock
  input  wire logic  core_clk_i,
  // host bus
  output logic [11:0] sa_o,
  output logic        cs_low_o,
  output logic        ior_low_o,
  output logic        iow_low_o,
  output logic        dack_low_o,
  output logic        mode16_o,
  // upper address on the shared disk2 pins
  output logic [3:1]  upper_o
);
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  initial begin
    sa_o       = 12'h000;
    cs_low_o   = 1'b1;
    ior_low_o  = 1'b1;
    iow_low_o  = 1'b1;
    dack_low_o = 1'b1;
    mode16_o   = 1'b0;
    upper_o    = 3'h0;
  end

  task automatic set_wide(input logic w);
    @(posedge core_clk_i);
    mode16_o <= w;
  endtask

  // one strobe at a time; returns just after the sampling edge
  task automatic access(input logic [11:0] a, input logic rd, input logic dma,
                        input logic [3:0] up, input logic csn);
    @(posedge core_clk_i);
    sa_o       <= a;
    ior_low_o  <= ~rd;
    iow_low_o  <= rd;
    dack_low_o <= ~dma;
    upper_o    <= up[3:1];
    // narrow board drives select from csn; wide board puts sa12 on it
    cs_low_o   <= mode16_o ? up[0] : csn;
    @(posedge core_clk_i);
    #1;
  endtask
endmodule // hpd_host_model

//--- verif/host_port_address_decode_tb.sv
`timescale 1ns/1ps

module host_port_address_decode_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                 core_clk;
  logic                 rst;
  hpd_pkg::hpd_cfg_wr_t cfg;
  hpd_pkg::hpd_sel_t    sel;
  logic                 drive;
  logic [11:0]          sa;
  logic                 cs_low;
  logic                 ior_low;
  logic                 iow_low;
  logic                 dack_low;
  logic                 mode16;
  logic [3:1]           upper;
  logic                 d1a;
  logic                 d1b;
  logic                 d2a_o;
  logic                 d2a_oe;
  logic                 d2b_o;
  logic                 d2b_oe;
  logic                 d2a_pin;
  logic                 d2b_pin;
  logic                 irq_pin;
  int                   mismatches;
  int                   n_tests;
  int                   cycles;

  // pins pulled up while nobody drives them
  assign d2a_pin = d2a_oe ? d2a_o : (mode16 ? upper[1] : 1'b1);
  assign d2b_pin = d2b_oe ? d2b_o : (mode16 ? upper[2] : 1'b1);
  assign irq_pin = mode16 ? upper[3] : 1'b0;

  hpd_host_model host (.core_clk_i(core_clk), .sa_o(sa), .cs_low_o(cs_low),
    .ior_low_o(ior_low), .iow_low_o(iow_low), .dack_low_o(dack_low),
    .mode16_o(mode16), .upper_o(upper));

  hpd_decode DUT (.core_clk_i(core_clk), .rst_i(rst), .sa_i(sa),
    .device_select_low_i(cs_low), .ior_low_i(ior_low), .iow_low_i(iow_low),
    .dack_low_i(dack_low), .addr_mode16_i(mode16), .cfg_i(cfg),
    .disk1_select_a_low_o(d1a), .disk1_select_b_low_o(d1b),
    .disk2_select_a_low_i(d2a_pin), .disk2_select_a_low_o(d2a_o),
    .disk2_select_a_oe_o(d2a_oe), .disk2_select_b_low_i(d2b_pin),
    .disk2_select_b_low_o(d2b_o), .disk2_select_b_oe_o(d2b_oe),
    .disk2_irq_in_i(irq_pin), .sel_o(sel), .data_drive_o(drive));

  // ****************************************************************
  // helpers
  // ****************************************************************
  always #2 core_clk = ~core_clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [5:0] oh, input logic [2:0] ofs);
    host.access(a, 1'b1, 1'b0, 4'h0, 1'b0);
    chk(sel.onehot, oh);
    chk(drive, |oh);
    if (oh != 6'h00) chk(sel.offset, ofs);
  endtask

  task automatic load(input hpd_pkg::hpd_blk_t b, input logic [11:0] base,
                      input hpd_pkg::hpd_pmode_t pm);
    @(posedge core_clk);
    cfg <= {1'b1, b, 1'b0, base, 1'b1, pm};
    @(posedge core_clk);
    cfg.load <= 1'b0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_map();
    logic [11:0] a [10];
    logic [5:0]  oh [10];
    logic [2:0]  of [10];
    a  = '{12'h3f5, 12'h3f7, 12'h3f6, 12'h1f7, 12'h37b, 12'h37c, 12'h3ff, 12'h2f8,
           12'h170, 12'h1f1};
    oh = '{6'h01, 6'h01, 6'h02, 6'h02, 6'h08, 6'h00, 6'h10, 6'h20, 6'h00, 6'h02};
    of = '{3'h5, 3'h7, 3'h0, 3'h7, 3'h3, 3'h0, 3'h7, 3'h0, 3'h0, 3'h1};
    for (int i = 0; i < 10; i++) begin
      rd_chk(a[i], oh[i], of[i]);
    end
    chk(sel.wide16, 1'b0);
    rd_chk(12'h1f0, 6'h02, 3'h0);
    chk(sel.wide16, 1'b1);
    chk(d1a, 1'b0);
    rd_chk(12'h3f6, 6'h02, 3'h0);
    chk({sel.second, d1b, d1a}, 3'b101);
  endtask

  task automatic t_sel_dir();
    host.access(12'h3f5, 1'b1, 1'b0, 4'h0, 1'b1);
    chk(sel.onehot, 6'h00);
    chk(drive, 1'b0);
    host.access(12'h3f4, 1'b0, 1'b0, 4'h0, 1'b0);
    chk({sel.onehot, sel.wr, sel.rd, drive}, {6'h01, 3'b100});
    rd_chk(12'h3f4, 6'h01, 3'h4);
    chk({sel.wr, sel.rd}, 2'b01);
    host.access(12'h000, 1'b1, 1'b1, 4'h0, 1'b0);
    chk({sel.onehot, sel.offset, sel.dma}, {6'h01, 3'h5, 1'b1});
  endtask

  task automatic t_reloc();
    load(hpd_pkg::HPD_BLK_COM1, 12'h2e8, hpd_pkg::HPD_PM_SPP);
    rd_chk(12'h2e8, 6'h10, 3'h0);
    rd_chk(12'h3f8, 6'h00, 3'h0);
    load(hpd_pkg::HPD_BLK_PAR, 12'h378, hpd_pkg::HPD_PM_ECP);
    rd_chk(12'h779, 6'h08, 3'h1);
    chk(sel.ext_win, 1'b1);
    rd_chk(12'h37c, 6'h00, 3'h0);
    load(hpd_pkg::HPD_BLK_PAR, 12'h378, hpd_pkg::HPD_PM_ECP_EPP);
    rd_chk(12'h37c, 6'h08, 3'h4);
  endtask

  task automatic t_disk2();
    chk({d2a_oe, d2b_oe, d2a_pin, d2b_pin}, 4'b0011);
    load(hpd_pkg::HPD_BLK_DISK2, 12'h170, hpd_pkg::HPD_PM_SPP);
    repeat (2) @(posedge core_clk);
    #1;
    chk({d2a_oe, d2b_oe}, 2'b11);
    rd_chk(12'h172, 6'h04, 3'h2);
    chk({d2a_pin, d2b_pin}, 2'b01);
  endtask

  task automatic t_wide();
    host.set_wide(1'b1);
    host.access(12'h3f5, 1'b1, 1'b0, 4'h0, 1'b0);
    chk({sel.onehot, d2a_oe, d2b_oe}, {6'h01, 2'b00});
    host.access(12'h3f5, 1'b1, 1'b0, 4'h4, 1'b0);
    chk(sel.onehot, 6'h00);
    host.access(12'h3f5, 1'b1, 1'b0, 4'h1, 1'b0);
    chk(drive, 1'b0);
    host.access(12'h3f5, 1'b1, 1'b0, 4'h8, 1'b0);
    chk({sel.onehot, drive}, 7'h00);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    core_clk   = 1'b0;
    rst        = 1'b1;
    cfg        = '0;
    mismatches = 0;
    n_tests    = 0;
    cycles     = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({sel, drive, d1a, d1b}, {$bits(sel) + 3{1'b0}} | 3'b011);
    t_map();
    t_sel_dir();
    t_reloc();
    t_disk2();
    t_wide();
    conclude();
  end
endmodule // host_port_address_decode_tb
